// file: bench/oled_host_interface_select_tb_top.sv
// Purpose: end-to-end bench, host registers to device outputs
// Assumes: hready looped back from the one slave
// Notes: expected bytes queue as {dc, byte}
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t value differs", $time); end end
module oled_host_interface_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, hsel, hwrite, hready, rxv, rxd, mval;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0] rxb, ctr;
  logic [6:0] addr;
  logic [2:0] disp, mode;
  logic [8:0] exp_q[$]; // {dc, byte} still owed
  int mismatches, n_checks, cyc, seed;
  logic [2:0] modes [6] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
  oled_link_if link ();
  oled_host_end u_oled_host_end (.i_clk_sys(clk), .i_reset_n(rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata),
    .o_hresp(), .link(link));
  oled_dev_end u_oled_dev_end (.i_clk_sys(clk), .i_reset_n(rst_n), .link(link),
    .o_rx_valid(rxv), .o_rx_byte(rxb), .o_rx_is_data(rxd), .o_display_ctl(disp),
    .o_ddram_addr(addr), .o_contrast(ctr), .o_mode(mode), .o_mode_valid(mval));
  oled_link_sva u_oled_link_sva (.i_clk_sys(clk), .i_reset_n(rst_n),
    .host_cs_n(link.host_cs_n), .host_dc(link.host_dc), .host_rw(link.host_rw),
    .host_rd(link.host_rd), .host_straps(link.host_straps),
    .host_strap0_en(link.host_strap0_en), .host_doe(link.host_doe),
    .dev_doe(link.dev_doe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // single word transfer, waits on the slave's own ready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic send(input logic dc, input logic [7:0] v, input logic q);
    if (q) exp_q.push_back({dc, v});
    ahb(1'b1, oled_pkg::REG_TX, {23'h0, dc, v});
  endtask
  task automatic idle();
    do ahb(1'b0, oled_pkg::REG_STAT, 32'h0); while (r[0] !== 1'b0);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watcher: every received byte must match the oldest note
  always @(posedge clk) begin
    cyc++;
    if (cyc > 90000) begin
      mismatches++;
      final_report();
    end else if (rst_n && rxv === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK({rxd, rxb}, exp_q.pop_front())
    end
  end
  initial begin
    seed = 32'h2a72;
    hsel = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // one random data byte in every valid mode
    foreach (modes[i]) begin
      ahb(1'b1, oled_pkg::REG_CTRL, {29'h1, modes[i]});
      send(1'b1, 8'($random(seed)), 1'b1);
      idle();
    end
    send(1'b0, 8'h0f, 1'b1);
    send(1'b0, oled_pkg::CMD_CONTRAST, 1'b1);
    send(1'b0, 8'h3c, 1'b1);
    ahb(1'b1, oled_pkg::REG_RDREQ, 32'h0);
    idle();
    ahb(1'b0, oled_pkg::REG_RDDATA, 32'h0);
    `CHK(r[7:0], 8'h06)
    `CHK({disp, ctr}, {3'h7, 8'h3c})
    ahb(1'b1, oled_pkg::REG_CTRL, 32'h1f);
    repeat (4) @(posedge clk);
    `CHK({disp, addr, ctr}, {3'h0, 7'h00, 8'h7f})
    // invalid code: nothing may arrive
    ahb(1'b1, oled_pkg::REG_CTRL, 32'h09);
    send(1'b1, 8'ha5, 1'b0);
    idle();
    `CHK(mval, 1'b0)
    ahb(1'b1, oled_pkg::REG_CTRL, 32'h01);
    send(1'b1, 8'h5a, 1'b1);
    idle();
    `CHK(mode, oled_pkg::BS_SERIAL)
    // queue filled back to back, link drains slowly
    ahb(1'b1, oled_pkg::REG_CTRL, 32'h1c);
    ahb(1'b1, oled_pkg::REG_CTRL, 32'h0c);
    repeat (9) send(1'b1, 8'($random(seed)), 1'b1);
    ahb(1'b0, oled_pkg::REG_STAT, 32'h0);
    `CHK(r[2], 1'b1)
    idle();
    ahb(1'b1, oled_pkg::REG_RDREQ, 32'h0);
    idle();
    ahb(1'b0, oled_pkg::REG_RDDATA, 32'h0);
    `CHK(r[7:0], 8'h09)
    // set-address command, then read the counter back
    send(1'b0, 8'hc5, 1'b1);
    ahb(1'b1, oled_pkg::REG_RDREQ, 32'h0);
    idle();
    ahb(1'b0, oled_pkg::REG_RDDATA, 32'h0);
    `CHK(r[7:0], 8'h45)
    ahb(1'b0, 8'h20, 32'h0); // unmapped
    `CHK(r, 32'h0)
    `CHK(exp_q.size(), 0)
    final_report();
  end
endmodule // oled_host_interface_select_tb_top

// file: bench/oled_link_sva.sv
// Purpose: pin checks between host end and device end
// Assumes: one clock, async low reset
// Notes: straps seen after the lowest-bit pull-down
module oled_link_sva (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // link pins
  input wire logic host_cs_n,
  input wire logic host_dc,
  input wire logic host_rw,
  input wire logic host_rd,
  input wire logic [2:0] host_straps,
  input wire logic host_strap0_en,
  input wire logic [7:0] host_doe,
  input wire logic [7:0] dev_doe
);
  logic [2:0] sv; // code the device decodes
  logic m68; // 6800 style parallel
  assign sv = oled_pkg::strap_value(host_straps, host_strap0_en);
  assign m68 = sv[2] & ~sv[1];
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // repetitions leave one or two cycles of slack for register updates
  a_cs_gates_drive: assert property (host_cs_n [*3] |-> dev_doe == 8'h00)
    else $error("drive while deselected");
  a_invalid_no_drive: assert property ((!oled_pkg::mode_valid(sv)) [*3] |-> dev_doe == 8'h00)
    else $error("drive in invalid mode");
  a_serial_rw_low: assert property ((sv inside {3'h0, 3'h2}) [*2] |-> !host_rw)
    else $error("rw high in serial mode");
  a_bus_no_clash: assert property (sv[2] |-> (host_doe & dev_doe) == 8'h00)
    else $error("both ends drive");
  a_read_dir: assert property ((|dev_doe) && m68 |-> host_rw)
    else $error("device drives on write");
  a_nibble_upper: assert property ((|dev_doe) && oled_pkg::is_4bit(sv) |-> dev_doe[3:0] == 4'h0)
    else $error("lower lines driven");
  a_wr_strobe_cs: assert property ((oled_pkg::is_8080(sv) && !host_rw) [*2] |-> !host_cs_n)
    else $error("write strobe outside select");
  a_rd_strobe_cs: assert property ((oled_pkg::is_8080(sv) && !host_rd) [*2] |-> !host_cs_n)
    else $error("read strobe outside select");
  a_enable_in_cs: assert property ((m68 && host_rd) [*2] |-> !host_cs_n)
    else $error("enable outside select");
  a_dc_held: assert property (sv[2] && !host_cs_n && $past(!host_cs_n) |-> $stable(host_dc))
    else $error("selector moved in transfer");
  c_m68: cover property ($fell(host_cs_n) && m68);
  c_i80: cover property ($fell(host_cs_n) && oled_pkg::is_8080(sv));
  c_read: cover property (|dev_doe);
endmodule // oled_link_sva

// file: hdl/oled_dev_end.sv
// Purpose: display side of the host link, all strap modes
// Assumes: pins sampled on i_clk_sys, strobes far slower than clock
// Notes: i2c is write only; ddram is a small character store
module oled_dev_end (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // link pins
  oled_link_if.device link,
  // received bytes
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte,
  output logic o_rx_is_data,
  // display state
  output logic [2:0] o_display_ctl,
  output logic [6:0] o_ddram_addr,
  output logic [7:0] o_contrast,
  output logic [2:0] o_mode,
  output logic o_mode_valid
);
  // ****************
  // types and state
  // ****************
  typedef enum logic [1:0] {I2C_IDLE, I2C_ADDR, I2C_CTRL, I2C_DATA} i2c_ph_t;
  typedef struct packed {
    logic e_q; // last enable / read strobe
    logic wr_q; // last direction / write strobe
    logic d0_q; // last serial clock
    logic d1_q; // last sda
    logic nib_q; // high nibble held
    logic [3:0] hi_q;
    logic rdnib_q; // second read nibble next
    logic [7:0] sh_q; // serial shifter
    logic [3:0] cnt_q;
    i2c_ph_t ph_q;
    logic co_q; // i2c continuation bit
    logic idc_q; // i2c data/command
    logic cpend_q; // contrast byte expected
    logic [2:0] disp_q;
    logic [6:0] addr_q;
    logic [7:0] cont_q;
    logic rxv_q;
    logic [7:0] rxb_q;
    logic rxdc_q;
    logic [7:0] dout_q;
    logic [7:0] doe_q;
    logic [2:0] mode_q;
    logic mval_q;
  } dev_state_t;

  dev_state_t q, d;
  logic [7:0] ram [oled_pkg::DDRAM_DEPTH]; // character store, not reset
  logic got; // a whole byte arrived
  logic [7:0] gb;
  logic gdc;
  logic ram_we;
  logic [2:0] m;
  logic sel;
  logic [7:0] rv; // value a read returns
  logic wstb;
  logic rdrive;
  logic rdone;
  logic ack;

  // initialised state, write strobe, 6800 enable and serial lines seen idle to avoid false edges; 8080 read strobe seen low
  function automatic dev_state_t dev_reset();
    dev_reset = '0;
    dev_reset.wr_q = 1'b1;
    dev_reset.e_q = 1'b0;
    dev_reset.d0_q = 1'b1;
    dev_reset.d1_q = 1'b1;
    dev_reset.disp_q = oled_pkg::DISP_RST;
    dev_reset.addr_q = oled_pkg::ADDR_RST;
    dev_reset.cont_q = oled_pkg::CONTRAST_RST;
  endfunction

  function automatic logic [6:0] next_addr(logic [6:0] a);
    next_addr = (a == oled_pkg::DDRAM_LAST) ? oled_pkg::ADDR_RST : a + 7'h01;
  endfunction

  // ****************
  // next state
  // ****************
  always_comb begin
    d = q;
    got = 1'b0;
    gb = 8'h00;
    gdc = 1'b0;
    ram_we = 1'b0;
    wstb = 1'b0;
    rdrive = 1'b0;
    rdone = 1'b0;
    ack = 1'b0;
    m = oled_pkg::strap_value(link.host_straps, link.host_strap0_en);
    sel = ~link.host_cs_n & oled_pkg::mode_valid(m);
    rv = link.host_dc ? ram[q.addr_q] : {1'b0, q.addr_q};
    d.rxv_q = 1'b0;
    d.mode_q = m;
    d.mval_q = oled_pkg::mode_valid(m);
    d.e_q = link.host_rd;
    d.wr_q = link.host_rw;
    d.d0_q = link.bus[0];
    d.d1_q = link.bus[1];
    if (!sel) begin
      // deselected or invalid code: bus released, link logic idle
      d.doe_q = 8'h00;
      d.cnt_q = 4'h0;
      d.ph_q = I2C_IDLE;
    end else begin
      case (m)
        oled_pkg::BS_SERIAL: begin
          d.doe_q = 8'h00;
          if (!q.d0_q && link.bus[0]) begin
            d.sh_q = {q.sh_q[6:0], link.bus[1]};
            if (q.cnt_q == 4'h7) begin
              got = 1'b1;
              gb = {q.sh_q[6:0], link.bus[1]};
              gdc = link.host_dc;
              d.cnt_q = 4'h0;
            end else begin
              d.cnt_q = q.cnt_q + 4'h1;
            end
          end
        end
        oled_pkg::BS_I2C: begin
          // scl on line 0, sda on tied lines 2/1
          if (q.d0_q && link.bus[0] && q.d1_q && !link.bus[1]) begin
            d.ph_q = I2C_ADDR; // start
            d.cnt_q = 4'h0;
            d.doe_q = 8'h00;
          end else if (q.d0_q && link.bus[0] && !q.d1_q && link.bus[1]) begin
            d.ph_q = I2C_IDLE; // stop
            d.doe_q = 8'h00;
          end else if (q.ph_q != I2C_IDLE) begin
            if (!q.d0_q && link.bus[0] && q.cnt_q < 4'h8) begin
              d.sh_q = {q.sh_q[6:0], link.bus[1]};
              d.cnt_q = q.cnt_q + 4'h1;
            end else if (q.d0_q && !link.bus[0]) begin
              if (q.cnt_q == 4'h8) begin
                // byte complete at falling scl: decide ack
                case (q.ph_q)
                  I2C_ADDR: begin
                    ack = (q.sh_q[7:1] == oled_pkg::I2C_ADDR) && !q.sh_q[0];
                    d.ph_q = ack ? I2C_CTRL : I2C_IDLE;
                  end
                  I2C_CTRL: begin
                    ack = 1'b1;
                    d.co_q = q.sh_q[7];
                    d.idc_q = q.sh_q[6];
                    d.ph_q = I2C_DATA;
                  end
                  default: begin
                    ack = 1'b1;
                    got = 1'b1;
                    gb = q.sh_q;
                    gdc = q.idc_q;
                    d.ph_q = q.co_q ? I2C_CTRL : I2C_DATA;
                  end
                endcase
                d.cnt_q = 4'h9;
                d.dout_q = 8'h00;
                d.doe_q = {5'h00, ack, 2'h0}; // ack pulls line 2 low
              end else if (q.cnt_q == 4'h9) begin
                d.cnt_q = 4'h0;
                d.doe_q = 8'h00;
              end
            end
          end
        end
        default: begin
          if (oled_pkg::is_8080(m)) begin
            wstb = !q.wr_q && link.host_rw;
            rdrive = !link.host_rd;
            rdone = !q.e_q && link.host_rd;
          end else begin
            wstb = q.e_q && !link.host_rd && !link.host_rw;
            rdrive = link.host_rd && link.host_rw;
            rdone = q.e_q && !link.host_rd && link.host_rw;
          end
          if (wstb) begin
            if (!oled_pkg::is_4bit(m)) begin
              got = 1'b1;
              gb = link.bus;
            end else if (!q.nib_q) begin
              d.nib_q = 1'b1;
              d.hi_q = link.bus[7:4];
            end else begin
              d.nib_q = 1'b0;
              got = 1'b1;
              gb = {q.hi_q, link.bus[7:4]};
            end
            gdc = link.host_dc;
          end
          // drive only during a read strobe
          if (oled_pkg::is_4bit(m)) begin
            d.dout_q = q.rdnib_q ? {rv[3:0], 4'h0} : {rv[7:4], 4'h0};
            d.doe_q = rdrive ? 8'hf0 : 8'h00;
          end else begin
            d.dout_q = rv;
            d.doe_q = rdrive ? 8'hff : 8'h00;
          end
          if (rdone) begin
            d.rdnib_q = oled_pkg::is_4bit(m) & ~q.rdnib_q;
            // data reads step the address once per whole byte
            if (link.host_dc && !(oled_pkg::is_4bit(m) && !q.rdnib_q)) begin
              d.addr_q = next_addr(q.addr_q);
            end
          end
        end
      endcase
    end
    // ****************
    // byte acceptance
    // ****************
    if (got) begin
      d.rxv_q = 1'b1;
      d.rxb_q = gb;
      d.rxdc_q = gdc;
      if (gdc) begin
        ram_we = 1'b1;
        d.addr_q = next_addr(q.addr_q);
      end else if (q.cpend_q) begin
        d.cpend_q = 1'b0;
        d.cont_q = gb;
      end else if (gb == oled_pkg::CMD_CONTRAST) begin
        d.cpend_q = 1'b1;
      end else if (gb[7]) begin
        d.addr_q = (gb[6:0] > oled_pkg::DDRAM_LAST) ? oled_pkg::ADDR_RST : gb[6:0];
      end else if (gb[7:3] == oled_pkg::CMD_DISP_CTL) begin
        d.disp_q = gb[2:0];
      end
    end
    if (!link.host_rst_n) begin
      d = dev_reset();
      d.mode_q = m;
      d.mval_q = oled_pkg::mode_valid(m);
      ram_we = 1'b0;
    end
  end

  // ****************
  // registers
  // ****************
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= dev_reset();
    end else begin
      q <= d;
    end
  end

  // character store write port
  always_ff @(posedge i_clk_sys) begin
    if (ram_we) begin
      ram[q.addr_q] <= gb;
    end
  end

  // ****************
  // outputs
  // ****************
  assign link.dev_dout = q.dout_q;
  assign link.dev_doe = q.doe_q;
  assign o_rx_valid = q.rxv_q;
  assign o_rx_byte = q.rxb_q;
  assign o_rx_is_data = q.rxdc_q;
  assign o_display_ctl = q.disp_q;
  assign o_ddram_addr = q.addr_q;
  assign o_contrast = q.cont_q;
  assign o_mode = q.mode_q;
  assign o_mode_valid = q.mval_q;
endmodule // oled_dev_end

// file: hdl/oled_host_end.sv
// Purpose: host controller driving the link from ahb-lite registers
// Assumes: single word transfers, hsize ignored, response always okay
// Notes: transfers queue in a fifo; a full fifo stretches the write
module oled_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
  } fifo_state_t;
  fifo_state_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  function automatic logic [AW-1:0] inc(logic [AW-1:0] p);
    inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign o_in_ready = q.cnt_q != (AW + 1)'(DEPTH); // honest full
  assign o_out_valid = q.cnt_q != '0;
  assign o_out_data = mem[q.rp_q];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // pointer and count update
  always_comb begin
    d = q;
    if (push) begin
      d.wp_q = inc(q.wp_q);
    end
    if (pop) begin
      d.rp_q = inc(q.rp_q);
    end
    d.cnt_q = q.cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // storage, no reset needed
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[q.wp_q] <= i_in_data;
    end
  end
endmodule // oled_fifo

module oled_host_end (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  // link pins
  oled_link_if.host link
);
  // ****************
  // state
  // ****************
  typedef struct packed {
    logic [4:0] ctrl_q; // rst hold, strap0 en, mode
    logic dp_q; // data phase pending
    logic rdy_q;
    logic [7:0] dpa_q;
    logic dpw_q;
    logic [31:0] hrdata_q;
    logic run_q;
    logic [9:0] ent_q; // read flag, dc, byte
    logic [1:0] step_q;
    logic [4:0] unit_q;
    logic [6:0] tmr_q;
    logic [7:0] rdat_q;
    logic rdv_q;
    logic cs_n_q;
    logic dc_q;
    logic rw_q;
    logic rd_q;
    logic [7:0] dout_q;
    logic [7:0] doe_q;
  } host_state_t;
  host_state_t q, d;
  logic f_in_valid;
  logic f_in_ready;
  logic f_out_valid;
  logic [9:0] f_out_data;
  logic [2:0] m;
  logic par;
  logic [1:0] last_step;
  logic [4:0] end_unit;
  logic s1;
  logic scl;
  logic sda;
  logic [7:0] nib;

  // i2c bit of unit u: address, control, data, ack slots released
  function automatic logic i2c_bit(logic [4:0] u, logic dc, logic [7:0] b);
    logic [4:0] j;
    logic [3:0] k;
    logic [7:0] by;
    j = u - 5'h01;
    k = 4'(j % 5'd9);
    by = (j < 5'd9) ? {oled_pkg::I2C_ADDR, 1'b0} : (j < 5'd18) ? {1'b0, dc, 6'h00} : b;
    i2c_bit = (k == 4'h8) ? 1'b1 : by[3'(4'h7 - k)];
  endfunction

  oled_fifo #(.WIDTH(oled_pkg::FIFO_W), .DEPTH(oled_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_in_valid(f_in_valid),
    .o_in_ready(f_in_ready),
    .i_in_data({q.dpa_q == oled_pkg::REG_RDREQ, i_hwdata[8:0]}),
    .o_out_valid(f_out_valid),
    .i_out_ready(!q.run_q),
    .o_out_data(f_out_data)
  );

  // queue push during the data phase of a tx or read request write
  assign f_in_valid = q.dp_q & !q.rdy_q & q.dpw_q &
    (q.dpa_q == oled_pkg::REG_TX || q.dpa_q == oled_pkg::REG_RDREQ);

  // ****************
  // bus and engine
  // ****************
  always_comb begin
    d = q;
    m = q.ctrl_q[2:0];
    par = m[2];
    // bus side: finish the data phase unless a queue push meets a full fifo
    if (q.dp_q && !q.rdy_q && (!f_in_valid || f_in_ready)) begin
      d.dp_q = 1'b0;
      d.rdy_q = 1'b1;
      d.hrdata_q = 32'h0;
      if (q.dpw_q && q.dpa_q == oled_pkg::REG_CTRL) begin
        d.ctrl_q = i_hwdata[4:0];
      end else if (!q.dpw_q) begin
        case (q.dpa_q)
          oled_pkg::REG_CTRL: d.hrdata_q = {27'h0, q.ctrl_q};
          oled_pkg::REG_STAT: d.hrdata_q = {29'h0, !f_in_ready, q.rdv_q, q.run_q | f_out_valid};
          oled_pkg::REG_RDDATA: begin
            d.hrdata_q = {24'h0, q.rdat_q};
            d.rdv_q = 1'b0;
          end
          default: d.hrdata_q = 32'h0;
        endcase
      end
    end
    if (i_hsel && i_hready && i_htrans[1]) begin
      d.dp_q = 1'b1;
      d.rdy_q = 1'b0;
      d.dpa_q = i_haddr[7:0];
      d.dpw_q = i_hwrite;
    end
    // engine timing per mode
    last_step = 2'h1;
    end_unit = 5'd8;
    if (par) begin
      last_step = 2'h2;
      end_unit = oled_pkg::is_4bit(m) ? 5'd2 : 5'd1;
    end else if (m == oled_pkg::BS_I2C) begin
      last_step = (q.unit_q == 5'd28) ? 2'h2 : 2'h1;
      end_unit = 5'd29;
    end
    if (!q.run_q && f_out_valid) begin
      d.run_q = 1'b1;
      d.ent_q = f_out_data;
      d.step_q = 2'h0;
      d.unit_q = 5'h0;
      d.tmr_q = 7'h0;
    end else if (q.run_q) begin
      if (q.tmr_q == 7'(oled_pkg::PHASE_CYC - 1)) begin
        d.tmr_q = 7'h0;
        if (par && q.ent_q[9] && q.step_q == 2'h1) begin
          // sample before the read strobe ends
          d.rdat_q = !oled_pkg::is_4bit(m) ? link.bus :
            (q.unit_q == 5'h0) ? {link.bus[7:4], q.rdat_q[3:0]} : {q.rdat_q[7:4], link.bus[7:4]};
        end
        if (q.step_q == last_step) begin
          d.step_q = 2'h0;
          d.unit_q = q.unit_q + 5'h01;
          if (q.unit_q + 5'h01 == end_unit) begin
            d.run_q = 1'b0;
            // keep a same-cycle clear from the data register, a new result wins
            d.rdv_q = d.rdv_q | q.ent_q[9];
          end
        end else begin
          d.step_q = q.step_q + 2'h1;
        end
      end else begin
        d.tmr_q = q.tmr_q + 7'h1;
      end
    end
    // pins from the next engine state
    s1 = d.run_q && d.step_q == 2'h1;
    nib = d.unit_q[0] ? {d.ent_q[3:0], 4'h0} : {d.ent_q[7:4], 4'h0};
    scl = 1'b1;
    sda = 1'b1;
    d.cs_n_q = !d.run_q;
    d.dc_q = d.ent_q[8];
    d.rw_q = 1'b0;
    d.rd_q = 1'b0;
    d.dout_q = 8'h00;
    d.doe_q = 8'h00;
    if (par) begin
      if (oled_pkg::is_8080(m)) begin
        d.rw_q = !(s1 && !d.ent_q[9]);
        d.rd_q = !(s1 && d.ent_q[9]);
      end else begin
        d.rw_q = d.ent_q[9];
        d.rd_q = s1;
      end
      d.dout_q = oled_pkg::is_4bit(m) ? nib : d.ent_q[7:0];
      if (d.run_q && !d.ent_q[9]) begin
        d.doe_q = oled_pkg::is_4bit(m) ? 8'hf0 : 8'hff;
      end
    end else if (m == oled_pkg::BS_I2C) begin
      if (d.run_q) begin
        if (d.unit_q == 5'h0) begin
          sda = d.step_q == 2'h0;
        end else if (d.unit_q == 5'd28) begin
          scl = d.step_q != 2'h0;
          sda = d.step_q == 2'h2;
        end else begin
          scl = s1;
          sda = i2c_bit(d.unit_q, d.ent_q[8], d.ent_q[7:0]);
        end
      end
      d.dout_q = {7'h00, scl};
      d.doe_q = {6'h00, !sda, 1'b1};
    end else begin
      d.dout_q = {6'h00, d.ent_q[3'h7 - d.unit_q[2:0]], s1};
      d.doe_q = d.run_q ? 8'h03 : 8'h00;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
      q.ctrl_q <= oled_pkg::CTRL_RST;
      q.rdy_q <= 1'b1;
      q.cs_n_q <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ****************
  // outputs
  // ****************
  assign o_hreadyout = q.rdy_q;
  assign o_hrdata = q.hrdata_q;
  assign o_hresp = 1'b0;
  assign link.host_cs_n = q.cs_n_q;
  assign link.host_rst_n = !q.ctrl_q[oled_pkg::CTRL_RST_HOLD];
  assign link.host_dc = q.dc_q;
  assign link.host_rw = q.rw_q;
  assign link.host_rd = q.rd_q;
  assign link.host_straps = q.ctrl_q[2:0];
  assign link.host_strap0_en = q.ctrl_q[oled_pkg::CTRL_STRAP0_EN];
  assign link.host_dout = q.dout_q;
  assign link.host_doe = q.doe_q;
endmodule // oled_host_end

// file: hdl/oled_link_if.sv
// Purpose: pins between host end and device end
// Assumes: wired-and bus with pull-ups, enables high while driving
// Notes: the i2c tie of lines 2 and 1 is made here
interface oled_link_if;
  logic host_cs_n; // chip select, low active
  logic host_rst_n; // reset_input_low
  logic host_dc; // data_command_select
  logic host_rw; // direction / write strobe
  logic host_rd; // enable / read strobe
  logic [2:0] host_straps; // interface_select_straps
  logic host_strap0_en; // lowest strap connected
  logic [7:0] host_dout;
  logic [7:0] host_doe;
  logic [7:0] dev_dout;
  logic [7:0] dev_doe;
  logic [7:0] wired;
  logic [7:0] bus; // host_data_bus as seen by both
  // pull-up unless someone drives low
  assign wired = (~host_doe | host_dout) & (~dev_doe | dev_dout);
  // i2c: sda out and in share one wire
  assign bus = (oled_pkg::strap_value(host_straps, host_strap0_en) == oled_pkg::BS_I2C) ?
    {wired[7:3], {2{wired[2] & wired[1]}}, wired[0]} : wired;
  modport device (input host_cs_n, host_rst_n, host_dc, host_rw, host_rd, host_straps,
    host_strap0_en, bus, output dev_dout, dev_doe);
  modport host (output host_cs_n, host_rst_n, host_dc, host_rw, host_rd, host_straps,
    host_strap0_en, host_dout, host_doe, input bus);
endinterface

// file: hdl/oled_pkg.sv
// Purpose: shared constants of the oled host link, both ends
// Assumes: one 250 MHz clock, pins sampled synchronously
// Notes: host end is an ahb-lite slave, device end models the display port
// Contract
// - device answers only while chip select low
// - reset input low initialises the device
// - selector high means data, low command
// - 6800: direction high read, low write
// - 8080: direction pin is write strobe
// - serial modes: host ties direction pin low
// - 6800: read/enable pin is bus enable
// - 8080: read/enable pin is read strobe
// - parallel: 8-line bus, device drives reads only
// - serial: data on line 1, clock line 0
// - i2c: lines 2,1 tied sda, scl line 0
// - decode strap code, 001/011 invalid
// - lowest strap pulled low when undriven
// - reset: display off, address zero, contrast 7f
package oled_pkg;
  // ****************
  // timing
  // ****************
  localparam int CLK_MHZ = 250;
  localparam int T_PHASE_NS = 260; // one pin phase, covers read low time
  localparam int PHASE_CYC = (T_PHASE_NS * CLK_MHZ + 999) / 1000;
  // ****************
  // strap codes
  // ****************
  localparam logic [2:0] BS_SERIAL = 3'h0;
  localparam logic [2:0] BS_I2C = 3'h2;
  localparam logic [2:0] BS_6800_8 = 3'h4;
  localparam logic [2:0] BS_6800_4 = 3'h5;
  localparam logic [2:0] BS_8080_8 = 3'h6;
  localparam logic [2:0] BS_8080_4 = 3'h7;
  // ****************
  // device state
  // ****************
  localparam logic [7:0] CONTRAST_RST = 8'h7f;
  localparam logic [6:0] ADDR_RST = 7'h00;
  localparam logic [2:0] DISP_RST = 3'h0;
  localparam int DDRAM_DEPTH = 80;
  localparam logic [6:0] DDRAM_LAST = 7'h4f;
  localparam logic [4:0] CMD_DISP_CTL = 5'h01; // 0000_1dcb
  localparam logic [7:0] CMD_CONTRAST = 8'h03; // next byte is contrast
  localparam logic [6:0] I2C_ADDR = 7'h2e; // arbitrary value
  // ****************
  // host registers
  // ****************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TX = 8'h04;
  localparam logic [7:0] REG_RDREQ = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_RDDATA = 8'h10;
  localparam int CTRL_STRAP0_EN = 3;
  localparam int CTRL_RST_HOLD = 4;
  localparam logic [4:0] CTRL_RST = 5'h18;
  localparam int TX_DC_BIT = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = 10;
  // ****************
  // helpers
  // ****************
  function automatic logic [2:0] strap_value(logic [2:0] raw, logic drv0);
    strap_value = {raw[2:1], raw[0] & drv0};
  endfunction
  function automatic logic mode_valid(logic [2:0] m);
    mode_valid = m[2] | ~m[0];
  endfunction
  function automatic logic is_4bit(logic [2:0] m);
    is_4bit = m[2] & m[0];
  endfunction
  function automatic logic is_8080(logic [2:0] m);
    is_8080 = m[2] & m[1];
  endfunction
endpackage
